// ===== iem_pkg.sv
// constants for the interrupt enable mask block
package iem_pkg;
   // source bit positions in every 5-bit field
   localparam int IEM_SRC_N = 5;
   localparam int IEM_TIMER_BIT = 0;
   localparam int IEM_INCHG_BIT = 1;
   localparam int IEM_EXT_BIT = 2;
   localparam int IEM_CMP_BIT = 3;
   localparam int IEM_PWM_BIT = 4;
   // register byte offsets on the bus
   localparam logic [7:0] IEM_ADR_MASK = 8'h00;
   localparam logic [7:0] IEM_ADR_STATUS = 8'h04;
   localparam logic [7:0] IEM_ADR_CLEAR = 8'h08;
   localparam logic [7:0] IEM_ADR_ENABLE = 8'h0c;
   // values after reset
   localparam logic [4:0] IEM_MASK_RST = 5'h00;
   localparam logic [4:0] IEM_ENABLE_RST = 5'h00;
   localparam logic [4:0] IEM_STATUS_RST = 5'h00;
   localparam logic [31:0] IEM_DAT_RST = 32'h0000_0000;
   // zero fill above the 5-bit fields
   localparam logic [26:0] IEM_FILL = 27'h000_0000;
endpackage

// ===== iem_gate_if.sv
// signals between the register top and the gating module
`timescale 1ns/100ps
interface iem_gate_if;
   logic [4:0] flags;
   logic [4:0] mask;
   logic [4:0] masked;
   logic any_req;
   logic cmp_wake;
   modport top (output flags, output mask, input masked, input any_req, input cmp_wake);
   modport gate (input flags, input mask, output masked, output any_req, output cmp_wake);
endinterface

// ===== iem_gate.sv
// per-source gating of the pending flags by the mask
`timescale 1ns/100ps
module iem_gate (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // flags and mask in, gated requests out
   iem_gate_if.gate g
);
   genvar i;
   generate
      for (i = 0; i < iem_pkg::IEM_SRC_N; i++) begin : g_src
         // flag passes only with its enable at 1
         assign g.masked[i] = g.flags[i] & g.mask[i];
      end
   endgenerate

   // combined request is the or of all gated flags
   assign g.any_req = |g.masked;

   // comparator change may wake or vector only when enabled
   assign g.cmp_wake = g.masked[iem_pkg::IEM_CMP_BIT];

   property p_any_tracks;
      @(posedge sys_clk) disable iff (sys_rst)
      (g.flags == 5'h00) |-> !g.any_req;
   endproperty
   a_any_tracks: assert property (p_any_tracks)
      else $error("request raised with no flag pending");

   cover property (@(posedge sys_clk) disable iff (sys_rst)
      (g.flags != 5'h00) && !g.any_req);
endmodule

// ===== iem_top.sv
// interrupt enable mask with wishbone registers and sticky status
//
// Operation
// - mask bit 4 lets the pwm period flag request an interrupt
// - mask bit 3 lets the comparator change flag request an interrupt
// - comparator change wakes or vectors the core only when mask bit 3 is 1
// - mask bit 2 lets the external pin flag request an interrupt
// - mask bit 1 lets the input change flag request an interrupt
// - mask bit 0 lets the timer overflow flag request an interrupt
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module iem_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // source flags
   input wire logic pwm_period_flag,
   input wire logic comparator_change_flag,
   input wire logic ext_pin_flag,
   input wire logic input_change_flag,
   input wire logic timer_overflow_flag,
   // requests
   output logic irq_req,
   output logic comparator_wake,
   output logic irq_o
);
   logic [4:0] mask_r;
   logic [4:0] mask_nxt;
   logic [4:0] en_r;
   logic [4:0] en_nxt;
   logic [4:0] stat_r;
   logic [4:0] stat_nxt;
   logic [4:0] prev_r;
   logic [4:0] prev_nxt;
   logic ack_r;
   logic ack_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic [4:0] flags;
   logic [4:0] rise;
   logic [4:0] clr;
   logic req;
   logic wr;

   iem_gate_if gif ();

   assign flags = {pwm_period_flag, comparator_change_flag, ext_pin_flag,
                   input_change_flag, timer_overflow_flag};
   assign gif.flags = flags;
   assign gif.mask = mask_r;

   iem_gate u_gate (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .g(gif.gate)
   );

   // bus access decode
   assign req = wb_cyc_i & wb_stb_i;
   assign wr = req & wb_we_i & ack_r & wb_sel_i[0];
   assign clr = (wr && wb_adr_i[7:2] == iem_pkg::IEM_ADR_CLEAR[7:2]) ? wb_dat_i[4:0] : 5'h00;
   // new gated request sets a sticky bit
   assign rise = gif.masked & ~prev_r;

   always_comb begin
      mask_nxt = mask_r;
      en_nxt = en_r;
      // upper mask bits are not stored and read as zero
      if (wr && wb_adr_i[7:2] == iem_pkg::IEM_ADR_MASK[7:2]) begin
         mask_nxt = wb_dat_i[4:0];
      end
      if (wr && wb_adr_i[7:2] == iem_pkg::IEM_ADR_ENABLE[7:2]) begin
         en_nxt = wb_dat_i[4:0];
      end
      // set wins over clear
      stat_nxt = (stat_r & ~clr) | rise;
      prev_nxt = gif.masked;
      ack_nxt = req & ~ack_r;
      dat_nxt = dat_r;
      if (req && !ack_r) begin
         unique case (wb_adr_i[7:2])
            iem_pkg::IEM_ADR_MASK[7:2]: dat_nxt = {iem_pkg::IEM_FILL, mask_r};
            iem_pkg::IEM_ADR_STATUS[7:2]: dat_nxt = {iem_pkg::IEM_FILL, stat_r};
            iem_pkg::IEM_ADR_ENABLE[7:2]: dat_nxt = {iem_pkg::IEM_FILL, en_r};
            default: dat_nxt = iem_pkg::IEM_DAT_RST;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mask_r <= iem_pkg::IEM_MASK_RST;
         en_r <= iem_pkg::IEM_ENABLE_RST;
         stat_r <= iem_pkg::IEM_STATUS_RST;
         prev_r <= iem_pkg::IEM_STATUS_RST;
         ack_r <= 1'b0;
         dat_r <= iem_pkg::IEM_DAT_RST;
      end else begin
         mask_r <= mask_nxt;
         en_r <= en_nxt;
         stat_r <= stat_nxt;
         prev_r <= prev_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign irq_req = gif.any_req;
   assign comparator_wake = gif.cmp_wake;
   assign irq_o = |(stat_r & en_r);

   property p_pwm_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      (pwm_period_flag && !mask_r[iem_pkg::IEM_PWM_BIT] && (flags[3:0] & mask_r[3:0]) == 4'h0)
         |-> !irq_req;
   endproperty
   a_pwm_gate: assert property (p_pwm_gate)
      else $error("pwm flag raised a request while disabled");

   property p_cmp_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      (comparator_change_flag && mask_r[iem_pkg::IEM_CMP_BIT]) |-> irq_req;
   endproperty
   a_cmp_gate: assert property (p_cmp_gate)
      else $error("enabled comparator flag gave no request");

   property p_cmp_wake;
      @(posedge sys_clk) disable iff (sys_rst)
      comparator_wake == (comparator_change_flag && mask_r[iem_pkg::IEM_CMP_BIT]);
   endproperty
   a_cmp_wake: assert property (p_cmp_wake)
      else $error("comparator wake differs from flag and enable");

   property p_ext_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      (ext_pin_flag && mask_r[iem_pkg::IEM_EXT_BIT]) |-> irq_req;
   endproperty
   a_ext_gate: assert property (p_ext_gate)
      else $error("enabled pin flag gave no request");

   property p_inchg_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      (input_change_flag && mask_r[iem_pkg::IEM_INCHG_BIT]) |-> irq_req;
   endproperty
   a_inchg_gate: assert property (p_inchg_gate)
      else $error("enabled input change flag gave no request");

   property p_timer_gate;
      @(posedge sys_clk) disable iff (sys_rst)
      (timer_overflow_flag && mask_r[iem_pkg::IEM_TIMER_BIT]) |-> irq_req;
   endproperty
   a_timer_gate: assert property (p_timer_gate)
      else $error("enabled timer flag gave no request");

   property p_req_or;
      @(posedge sys_clk) disable iff (sys_rst)
      irq_req == ((flags & mask_r) != 5'h00);
   endproperty
   a_req_or: assert property (p_req_or)
      else $error("combined request differs from or of gated flags");

   property p_mask_write;
      @(posedge sys_clk) disable iff (sys_rst)
      (wr && wb_adr_i[7:2] == iem_pkg::IEM_ADR_MASK[7:2])
         |=> mask_r == $past(wb_dat_i[4:0]);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask write not stored");

   property p_sticky;
      @(posedge sys_clk) disable iff (sys_rst)
      rise[iem_pkg::IEM_PWM_BIT] |=> stat_r[iem_pkg::IEM_PWM_BIT]
         ##1 (stat_r[iem_pkg::IEM_PWM_BIT] || $past(clr[iem_pkg::IEM_PWM_BIT]));
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("status bit not held after event");

   property p_ack_pulse;
      @(posedge sys_clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_read_fill;
      @(posedge sys_clk) disable iff (sys_rst)
      wb_ack_o |-> wb_dat_o[31:5] == 27'h000_0000;
   endproperty
   a_read_fill: assert property (p_read_fill)
      else $error("read data above bit 4 not zero");

   property p_status_set;
      @(posedge sys_clk) disable iff (sys_rst)
      rise != 5'h00 |=> (stat_r & $past(rise)) == $past(rise);
   endproperty
   a_status_set: assert property (p_status_set)
      else $error("gated event did not set its status bit");

   property p_status_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      (clr & ~rise) != 5'h00 |=> (stat_r & $past(clr) & ~$past(rise)) == 5'h00;
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("cleared status bit still set");

   property p_no_stray;
      @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> (stat_r & ~$past(stat_r) & ~$past(rise)) == 5'h00;
   endproperty
   a_no_stray: assert property (p_no_stray)
      else $error("status bit set without a gated event");

   cover property (@(posedge sys_clk) disable iff (sys_rst) irq_o);
   cover property (@(posedge sys_clk) disable iff (sys_rst) comparator_wake);
   cover property (@(posedge sys_clk) disable iff (sys_rst) (clr & rise) != 5'h00);
   cover property (@(posedge sys_clk) disable iff (sys_rst) wb_ack_o && !wb_we_i);
endmodule

// ===== iem_top_tb.sv
// self-checking bench for the interrupt enable mask block
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module iem_top_tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [4:0] flg = 5'h00;
   logic irq_req;
   logic comparator_wake;
   logic irq_o;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;
   iem_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pwm_period_flag(flg[4]), .comparator_change_flag(flg[3]),
      .ext_pin_flag(flg[2]), .input_change_flag(flg[1]), .timer_overflow_flag(flg[0]),
      .irq_req(irq_req), .comparator_wake(comparator_wake), .irq_o(irq_o));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc_cnt++;
      if (cyc_cnt > 4000) begin
         num_errors++;
         give_verdict;
      end
   end
   // one classic wishbone cycle, waits for ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] q);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do begin
         @(posedge sys_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, 4'hf, q);
      `CHK(q, e)
   endtask
   task automatic put(input logic [4:0] v);
      @(posedge sys_clk);
      flg <= v;
      #1;
   endtask
   task automatic t_regs;
      logic [31:0] q;
      rd(iem_pkg::IEM_ADR_MASK, 32'h0000_0000);
      rd(iem_pkg::IEM_ADR_ENABLE, 32'h0000_0000);
      rd(iem_pkg::IEM_ADR_STATUS, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      wr(iem_pkg::IEM_ADR_MASK, 32'h0000_00ff);
      rd(iem_pkg::IEM_ADR_MASK, 32'h0000_001f);
      // byte lane 0 off: write ignored
      bus(1'b1, iem_pkg::IEM_ADR_MASK, 32'h0000_0000, 4'he, q);
      rd(iem_pkg::IEM_ADR_MASK, 32'h0000_001f);
      wr(iem_pkg::IEM_ADR_ENABLE, 32'h0000_001f);
      rd(iem_pkg::IEM_ADR_ENABLE, 32'h0000_001f);
      wr(iem_pkg::IEM_ADR_ENABLE, 32'h0000_0000);
      // status is read only
      wr(iem_pkg::IEM_ADR_STATUS, 32'h0000_001f);
      rd(iem_pkg::IEM_ADR_STATUS, 32'h0000_0000);
      $display("regs done");
   endtask
   task automatic t_gate;
      logic [4:0] b;
      for (int i = 0; i < 5; i++) begin
         b = 5'h01 << i;
         wr(iem_pkg::IEM_ADR_MASK, {27'h0, b});
         put(~b);
         `CHK(irq_req, 1'b0)
         put(b);
         `CHK(irq_req, 1'b1)
         `CHK(comparator_wake, (i == 3))
         wr(iem_pkg::IEM_ADR_MASK, {27'h0, ~b});
         put(b);
         `CHK(irq_req, 1'b0)
         `CHK(comparator_wake, 1'b0)
         put(5'h1f);
         `CHK(irq_req, 1'b1)
      end
      put(5'h00);
      $display("gate done");
   endtask
   task automatic t_irq;
      wr(iem_pkg::IEM_ADR_CLEAR, 32'h0000_001f);
      rd(iem_pkg::IEM_ADR_STATUS, 32'h0000_0000);
      wr(iem_pkg::IEM_ADR_MASK, 32'h0000_0001);
      put(5'h04);
      put(5'h01);
      put(5'h00);
      rd(iem_pkg::IEM_ADR_STATUS, 32'h0000_0001);
      `CHK(irq_o, 1'b0)
      wr(iem_pkg::IEM_ADR_ENABLE, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(irq_o, 1'b1)
      wr(iem_pkg::IEM_ADR_CLEAR, 32'h0000_0001);
      rd(iem_pkg::IEM_ADR_CLEAR, 32'h0000_0000);
      `CHK(irq_o, 1'b0)
      rd(iem_pkg::IEM_ADR_STATUS, 32'h0000_0000);
      $display("irq done");
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_gate;
      t_irq;
      give_verdict;
   end
endmodule
